/* File: pwsm_power_state_manager.v */
// power state manager: state machine, stop-clock modulation, timers, gp latch
// assumes a single ahb-lite master and activity pins from outside this clock
`timescale 1ns/10ps
`default_nettype none
`include "pwsm_consts.vh"

module pwsm_power_state_manager #(
  parameter [8:0] DOZE_RELOAD = 9'h1ff,
  parameter [4:0] STBY_RELOAD = 5'h1f,
  parameter [6:0] SUSP_RELOAD = 7'h7f,
  parameter [8:0] HK_RELOAD   = 9'h1ff,
  parameter [8:0] PER_RELOAD  = 9'h1ff
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        irqHighAct,
  input  wire        irqZeroAct,
  input  wire        nmiAct,
  output reg         cpuStopClockN,
  output reg         mgmtInterruptN,
  output reg         gpLatchSelectN,
  output reg  [7:0]  gpLatchData
);

  // stop-clock asserted when phase is in the first 64>>code ms for codes 1-6; code 0 never, code 7 follows fullOk
  function stopAssert;
    input [2:0] code;
    input [5:0] phase;
    input       fullOk;
    begin
      if (code == 3'h0)
        stopAssert = 1'b0;
      else if (code == 3'h7)
        stopAssert = fullOk;
      else
        stopAssert = ({1'b0, phase} < (7'h40 >> code));
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // synchronise activity pins
  reg [2:0] actMeta_reg;
  reg [2:0] actSync_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      actMeta_reg <= 3'h0;
      actSync_reg <= 3'h0;
    end else begin
      actMeta_reg <= {irqHighAct, irqZeroAct, nmiAct};
      actSync_reg <= actMeta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0]  smiCtrl_reg;
  reg [7:0]  smiStat_reg;
  reg [7:0]  actStat_reg;
  reg [7:0]  state_reg;
  reg [7:0]  gp_reg;
  reg [7:0]  clkCtrl_reg;
  reg [7:0]  sysEn_reg;
  reg [7:0]  hkEn_reg;
  reg        swSmi_reg;
  reg        wrPend_reg;
  reg [7:0]  wrIdx_reg;

  wire        addrValid = hsel & hready & htrans[1];
  wire [7:0]  addrIdx   = haddr[9:2];
  wire        wrNow     = wrPend_reg;
  wire [7:0]  wb        = hwdata[7:0];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 8'h00;
    end else begin
      wrPend_reg <= addrValid & hwrite;
      wrIdx_reg  <= addrIdx;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // tick prescalers
  reg [6:0]  usCnt_reg;
  reg [9:0]  msCnt_reg;
  reg [9:0]  sCnt_reg;
  reg [5:0]  minCnt_reg;
  reg [5:0]  phase_reg;

  // last count of each prescaler, cut to its counter width
  localparam integer US_LAST_I  = `PWSM_US_CYCLES - 1;
  localparam integer MS_LAST_I  = `PWSM_MS_US - 1;
  localparam integer S_LAST_I   = `PWSM_S_MS - 1;
  localparam integer MIN_LAST_I = `PWSM_MIN_S - 1;
  localparam integer PH_LAST_I  = `PWSM_PERIOD_MS - 1;
  localparam [6:0]   US_LAST    = US_LAST_I[6:0];
  localparam [9:0]   MS_LAST    = MS_LAST_I[9:0];
  localparam [9:0]   S_LAST     = S_LAST_I[9:0];
  localparam [5:0]   MIN_LAST   = MIN_LAST_I[5:0];
  localparam [5:0]   PH_LAST    = PH_LAST_I[5:0];

  wire usTick  = state_reg[`PWSM_TST_US] |
                 (usCnt_reg == US_LAST);
  wire msTick  = state_reg[`PWSM_TST_MS] |
                 (usTick & (msCnt_reg == MS_LAST));
  wire sTick   = state_reg[`PWSM_TST_S] |
                 (msTick & (sCnt_reg == S_LAST));
  wire minTick = state_reg[`PWSM_TST_MIN] |
                 (sTick & (minCnt_reg == MIN_LAST));

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      usCnt_reg  <= 7'h00;
      msCnt_reg  <= 10'h000;
      sCnt_reg   <= 10'h000;
      minCnt_reg <= 6'h00;
      phase_reg  <= 6'h00;
    end else begin
      usCnt_reg <= usTick ? 7'h00 : usCnt_reg + 7'h01;
      if (usTick)
        msCnt_reg <= msTick ? 10'h000 : msCnt_reg + 10'h001;
      if (msTick)
        sCnt_reg <= sTick ? 10'h000 : sCnt_reg + 10'h001;
      if (sTick)
        minCnt_reg <= minTick ? 6'h00 : minCnt_reg + 6'h01;
      // both settings of the period bit run the same 64 ms phase
      if (msTick)
        phase_reg <= (phase_reg == PH_LAST) ?
                     6'h00 : phase_reg + 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // activity detection
  wire [2:0] cur       = state_reg[2:0];
  wire       inOn      = (cur == `PWSM_ST_ON);
  wire       inDoze    = (cur == `PWSM_ST_DOZE);
  wire       inStby    = (cur == `PWSM_ST_STBY);
  wire       inHk      = (cur == `PWSM_ST_DOZE_HK) | (cur == `PWSM_ST_STBY_HK);
  wire       sysAct    = |(actStat_reg & sysEn_reg & `PWSM_ACT_MASK);
  wire       hkAct     = |(actStat_reg & hkEn_reg & `PWSM_ACT_MASK);

  //////////////////////////////////////////////////////////////////////////
  // timers
  reg [8:0]  dozeTmr_reg;
  reg [4:0]  stbyTmr_reg;
  reg [6:0]  suspTmr_reg;
  reg [8:0]  hkTmr_reg;
  reg [8:0]  perTmr_reg;
  reg [2:0]  prevState_reg;
  wire dozeTo = inOn & sTick & (dozeTmr_reg == 9'h000);
  wire stbyTo = (inOn | inDoze) & minTick & (stbyTmr_reg == 5'h00);
  wire suspTo = inStby & minTick & (suspTmr_reg == 7'h00);
  wire hkTo   = inHk & msTick & (hkTmr_reg == 9'h000);
  wire stChg  = (prevState_reg != cur);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dozeTmr_reg   <= 9'h000;
      stbyTmr_reg   <= 5'h00;
      suspTmr_reg   <= 7'h00;
      hkTmr_reg     <= 9'h000;
      perTmr_reg    <= 9'h000;
      prevState_reg <= 3'h0;
    end else begin
      prevState_reg <= cur;
      if (sysAct | stChg | dozeTo)
        dozeTmr_reg <= DOZE_RELOAD;
      else if (inOn & sTick)
        dozeTmr_reg <= dozeTmr_reg - 9'h001;
      if (sysAct | inStby | stbyTo)
        stbyTmr_reg <= STBY_RELOAD;
      else if (minTick)
        stbyTmr_reg <= stbyTmr_reg - 5'h01;
      if (!inStby | suspTo)
        suspTmr_reg <= SUSP_RELOAD;
      else if (minTick)
        suspTmr_reg <= suspTmr_reg - 7'h01;
      if (stChg | hkTo)
        hkTmr_reg <= HK_RELOAD;
      else if (inHk & msTick)
        hkTmr_reg <= hkTmr_reg - 9'h001;
      if (sTick)
        perTmr_reg <= (perTmr_reg == 9'h000) ?
                      PER_RELOAD : perTmr_reg - 9'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state machine and register writes
  reg  [2:0] autoNext;
  reg        autoGo;
  always @* begin
    autoNext = cur;
    autoGo   = 1'b0;
    case (cur)
      `PWSM_ST_ON: begin
        if (stbyTo & !smiCtrl_reg[`PWSM_CTL_STBY]) begin
          autoNext = `PWSM_ST_STBY;
          autoGo   = 1'b1;
        end else if (dozeTo & !smiCtrl_reg[`PWSM_CTL_DOZE]) begin
          autoNext = `PWSM_ST_DOZE;
          autoGo   = 1'b1;
        end
      end
      `PWSM_ST_DOZE: begin
        if (sysAct & !smiCtrl_reg[`PWSM_CTL_SYS]) begin
          autoNext = `PWSM_ST_ON;
          autoGo   = 1'b1;
        end else if (hkAct & !smiCtrl_reg[`PWSM_CTL_HKACT]) begin
          autoNext = `PWSM_ST_DOZE_HK;
          autoGo   = 1'b1;
        end else if (stbyTo & !smiCtrl_reg[`PWSM_CTL_STBY]) begin
          autoNext = `PWSM_ST_STBY;
          autoGo   = 1'b1;
        end
      end
      `PWSM_ST_STBY: begin
        if (sysAct & !smiCtrl_reg[`PWSM_CTL_SYS]) begin
          autoNext = `PWSM_ST_ON;
          autoGo   = 1'b1;
        end else if (hkAct & !smiCtrl_reg[`PWSM_CTL_HKACT]) begin
          autoNext = `PWSM_ST_STBY_HK;
          autoGo   = 1'b1;
        end
      end
      `PWSM_ST_DOZE_HK, `PWSM_ST_STBY_HK: begin
        if (sysAct & !smiCtrl_reg[`PWSM_CTL_SYS]) begin
          autoNext = `PWSM_ST_ON;
          autoGo   = 1'b1;
        end else if (hkTo & !smiCtrl_reg[`PWSM_CTL_HKTO]) begin
          autoNext = (cur == `PWSM_ST_DOZE_HK) ?
                     `PWSM_ST_DOZE : `PWSM_ST_STBY;
          autoGo   = 1'b1;
        end
      end
      default: begin
        autoNext = cur;
        autoGo   = 1'b0;
      end
    endcase
  end

  wire autoDown = autoGo & ((autoNext == `PWSM_ST_DOZE) |
                            (autoNext == `PWSM_ST_STBY));
  wire swState  = wrNow & (wrIdx_reg == `PWSM_IDX_STATE);
  wire okCode   = (wb[2:0] != 3'h4) & (wb[2:0] != 3'h7);
  wire [7:0] actSet   = {actSync_reg, 5'h00};
  wire [7:0] actW1c   = (wrNow & (wrIdx_reg == `PWSM_IDX_ACT_STAT)) ?
                        wb : 8'h00;
  wire [7:0] actAuto  = autoDown ? ((sysEn_reg | hkEn_reg) & `PWSM_ACT_MASK)
                                 : 8'h00;
  wire [7:0] stsSet   = {dozeTo, stbyTo, suspTo, hkTo, 4'h0};
  wire [7:0] stsW1c   = (wrNow & (wrIdx_reg == `PWSM_IDX_SMI_STAT)) ?
                        wb : 8'h00;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smiCtrl_reg <= `PWSM_RST_BYTE;
      smiStat_reg <= `PWSM_RST_BYTE;
      actStat_reg <= `PWSM_RST_BYTE;
      state_reg   <= `PWSM_RST_BYTE;
      gp_reg      <= `PWSM_RST_BYTE;
      clkCtrl_reg <= `PWSM_RST_BYTE;
      sysEn_reg   <= `PWSM_RST_BYTE;
      hkEn_reg    <= `PWSM_RST_BYTE;
      swSmi_reg   <= 1'b0;
    end else begin
      // set wins over write-one clear and automatic clear
      actStat_reg <= ((actStat_reg & ~actW1c & ~actAuto) | actSet) &
                     `PWSM_ACT_MASK;
      smiStat_reg <= (smiStat_reg & ~stsW1c) | stsSet;
      swSmi_reg   <= (swSmi_reg & ~(stsW1c[7] &
                      (wrIdx_reg == `PWSM_IDX_SMI_STAT))) |
                     (wrNow & (wrIdx_reg == `PWSM_IDX_SMI_CTRL) &
                      wb[`PWSM_CTL_SWSMI]);
      if (swState) begin
        state_reg[6:3] <= wb[6:3];
        if (okCode)
          state_reg[2:0] <= wb[2:0];
        else
          state_reg[2:0] <= cur;
      end else begin
        state_reg[2:0] <= autoNext;
      end
      if (wrNow) begin
        case (wrIdx_reg)
          `PWSM_IDX_SMI_CTRL: smiCtrl_reg <= {wb[7:2], 2'h0};
          `PWSM_IDX_GP:       gp_reg      <= wb;
          `PWSM_IDX_CLK_CTRL: clkCtrl_reg <= {wb[7:1], 1'b0};
          `PWSM_IDX_SYS_EN:   sysEn_reg   <= wb & `PWSM_ACT_MASK;
          `PWSM_IDX_HK_EN:    hkEn_reg    <= wb & `PWSM_ACT_MASK;
          default:            gp_reg      <= gp_reg;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt, stop-clock and latch outputs
  wire smiPend = (smiStat_reg[7] & smiCtrl_reg[`PWSM_CTL_DOZE]) |
                 (smiStat_reg[6] & smiCtrl_reg[`PWSM_CTL_STBY]) |
                 (smiStat_reg[5] & smiCtrl_reg[`PWSM_CTL_SUSP]) |
                 (smiStat_reg[4] & smiCtrl_reg[`PWSM_CTL_HKTO]) |
                 (hkAct & smiCtrl_reg[`PWSM_CTL_HKACT]) |
                 (sysAct & smiCtrl_reg[`PWSM_CTL_SYS]) | swSmi_reg;
  wire useHigh = inOn | inHk;
  wire stopOn  = useHigh ? stopAssert(clkCtrl_reg[7:5], phase_reg, 1'b0)
                         : stopAssert(clkCtrl_reg[4:2], phase_reg, 1'b1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuStopClockN  <= 1'b1;
      mgmtInterruptN <= 1'b1;
      gpLatchSelectN <= 1'b1;
      gpLatchData    <= 8'h00;
    end else begin
      mgmtInterruptN <= ~smiPend;
      cpuStopClockN  <= ~(stopOn & ~smiPend);
      gpLatchSelectN <= ~(wrNow & (wrIdx_reg == `PWSM_IDX_GP));
      if (wrNow & (wrIdx_reg == `PWSM_IDX_GP))
        gpLatchData <= wb;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite read path
  reg [7:0] rdByte;
  always @* begin
    case (addrIdx)
      `PWSM_IDX_SMI_CTRL: rdByte = smiCtrl_reg;
      `PWSM_IDX_SMI_STAT: rdByte = {smiStat_reg[7:4], hkAct, sysAct, 2'h0};
      `PWSM_IDX_ACT_STAT: rdByte = actStat_reg;
      `PWSM_IDX_STATE:    rdByte = state_reg;
      `PWSM_IDX_GP:       rdByte = gp_reg;
      `PWSM_IDX_CLK_CTRL: rdByte = clkCtrl_reg;
      `PWSM_IDX_DOZE_TMR: rdByte = dozeTmr_reg[8:1];
      `PWSM_IDX_STBY_TMR: rdByte = {3'h0, stbyTmr_reg};
      `PWSM_IDX_SUSP_TMR: rdByte = {1'b0, suspTmr_reg};
      `PWSM_IDX_HK_TMR:   rdByte = hkTmr_reg[8:1];
      `PWSM_IDX_PER_TMR:  rdByte = perTmr_reg[8:1];
      `PWSM_IDX_SYS_EN:   rdByte = sysEn_reg;
      `PWSM_IDX_HK_EN:    rdByte = hkEn_reg;
      default:            rdByte = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrValid & !hwrite)
        hrdata <= {24'h000000, rdByte};
    end
  end

endmodule // pwsm_power_state_manager
`default_nettype wire

/* File: pwsm_consts.vh */
// constants for the power state manager: register indices, fields, timing
// assumes a 125 MHz clock and an ahb-lite register port, byte addr = 4*index
// Operation
// - irq/nmi activity status: bit7 irq15-1, bit6 irq0, bit5 nmi, reset zero
// - state bits 6..3 make us/ms/s/min ticks run every clock; keep zero
// - state bits 2..0 show current state with the fixed state codes
// - doze time-out in power-on: go doze if ctrl bit7 zero, else interrupt
// - in doze, system activity wakes to power-on if bit2 zero, else interrupt
// - in doze, housekeeping activity enters doze housekeeping if bit4 zero
// - housekeeping timer expiry returns to doze/standby if bit3 zero
// - in housekeeping states, system activity goes to power-on if bit2 zero
// - standby time-out in doze or power-on enters standby if bit6 zero
// - in standby, system activity wakes to power-on if bit2 zero
// - in standby, housekeeping activity enters standby housekeeping if bit4 zero
// - suspend is entered only by a software write of the state
// - general purpose write stores byte and updates external latch data
// - latch select strobe pulses low for one cycle after a general purpose write
// - power-on and housekeeping use ctrl bits 7..5 as stop-clock fraction
// - doze/standby/suspend use bits 4..2; code 111 asserts whole period
// - pending management interrupt forces stop-clock deasserted
// - ctrl bit1 picks modulation period; both settings give 64 ms
// - doze timer is 9 bits, readback shows bits 8..1
// - standby timer is 5 bits, readback bits 4..0, upper bits zero
// - suspend timer is 7 bits, readback bits 6..0, bit7 zero
// - housekeeping and peripheral timers 9 bits, readback bits 8..1
// - activity bits clear by write-one, reset, or automatic doze/standby entry if set in the sys or hk enable
`ifndef PWSM_CONSTS_VH
`define PWSM_CONSTS_VH
`define PWSM_IDX_SMI_CTRL   8'h72
`define PWSM_IDX_SMI_STAT   8'h73
`define PWSM_IDX_ACT_STAT   8'h79
`define PWSM_IDX_STATE      8'h7a
`define PWSM_IDX_GP         8'h7b
`define PWSM_IDX_CLK_CTRL   8'h7c
`define PWSM_IDX_DOZE_TMR   8'h88
`define PWSM_IDX_STBY_TMR   8'h89
`define PWSM_IDX_SUSP_TMR   8'h8a
`define PWSM_IDX_HK_TMR     8'h8b
`define PWSM_IDX_PER_TMR    8'h8c
`define PWSM_IDX_SYS_EN     8'h90
`define PWSM_IDX_HK_EN      8'h91
`define PWSM_ST_ON          3'h0
`define PWSM_ST_DOZE        3'h1
`define PWSM_ST_STBY        3'h2
`define PWSM_ST_SUSP        3'h3
`define PWSM_ST_DOZE_HK     3'h5
`define PWSM_ST_STBY_HK     3'h6
`define PWSM_CTL_DOZE       7
`define PWSM_CTL_STBY       6
`define PWSM_CTL_SUSP       5
`define PWSM_CTL_HKACT      4
`define PWSM_CTL_HKTO       3
`define PWSM_CTL_SYS        2
`define PWSM_CTL_SWSMI      1
`define PWSM_TST_US         6
`define PWSM_TST_MS         5
`define PWSM_TST_S          4
`define PWSM_TST_MIN        3
`define PWSM_RST_BYTE       8'h00
`define PWSM_ACT_MASK       8'he0
`define PWSM_CLK_NS         8
`define PWSM_US_NS          1000
`define PWSM_US_CYCLES      (`PWSM_US_NS / `PWSM_CLK_NS)
`define PWSM_MS_US          1000
`define PWSM_S_MS           1000
`define PWSM_MIN_S          60
`define PWSM_PERIOD_MS      64
`endif

/* File: pwsm_power_state_manager_assertions.sv */
// checker for the power state manager: bus answers, gp strobe, stop-clock
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
`default_nettype none
module pwsm_checker (
  input wire        clk,
  input wire        rstn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        cpuStopClockN,
  input wire        mgmtInterruptN,
  input wire        gpLatchSelectN,
  input wire [7:0]  gpLatchData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire       taken = hsel & hready & htrans[1];
  wire       gpWr  = taken & hwrite & (haddr[9:2] == 8'h7b);
  wire [7:0] wLow  = hwdata[7:0];
  sequence s_rd(idx); taken && !hwrite && haddr[9:2] == idx; endsequence
  sequence s_gp; gpWr ##1 1'b1; endsequence
  sequence s_pulse; !gpLatchSelectN ##1 gpLatchSelectN; endsequence
  property p_gp_strobe; gpWr |-> ##2 s_pulse; endproperty
  a_gp_strobe: assert property (p_gp_strobe)
    else $error("gp strobe missing after gp write");
  property p_gp_data; s_gp |-> ##1 gpLatchData == $past(wLow); endproperty
  a_gp_data: assert property (p_gp_data)
    else $error("gp latch data differs from written byte");
  property p_gp_only; $fell(gpLatchSelectN) |-> $past(gpWr, 2); endproperty
  a_gp_only: assert property (p_gp_only)
    else $error("gp strobe without gp write");
  property p_smi_stop; !mgmtInterruptN |-> cpuStopClockN; endproperty
  a_smi_stop: assert property (p_smi_stop)
    else $error("stop-clock asserted while interrupt pending");
  property p_act_rsvd;
    s_rd(8'h79) |-> ##1 hrdata[4:0] == 5'h00 && hrdata[31:8] == 24'h0;
  endproperty
  a_act_rsvd: assert property (p_act_rsvd)
    else $error("activity status reserved bits set");
  property p_state_code;
    s_rd(8'h7a) |-> ##1 hrdata[2:0] != 3'h4 && hrdata[2:0] != 3'h7;
  endproperty
  a_state_code: assert property (p_state_code)
    else $error("state readback holds a reserved code");
  property p_stby_rb; s_rd(8'h89) |-> ##1 hrdata[7:5] == 3'h0; endproperty
  a_stby_rb: assert property (p_stby_rb)
    else $error("standby timer readback upper bits set");
  property p_susp_rb; s_rd(8'h8a) |-> ##1 !hrdata[7]; endproperty
  a_susp_rb: assert property (p_susp_rb)
    else $error("suspend timer readback bit 7 set");
  property p_bus_ok; taken |-> ##1 hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus answer not ready or not okay");
endmodule // pwsm_checker
bind pwsm_power_state_manager pwsm_checker u_chk (.clk, .rstn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .cpuStopClockN, .mgmtInterruptN, .gpLatchSelectN, .gpLatchData);
`default_nettype wire

/* File: pwsm_host_model.sv */
// host side model: counts cycles with the processor clock stopped
// assumes stop-clock is active low and sampled on clk
`timescale 1ns/10ps
`default_nettype none
module pwsm_host_model (
  input  wire         clk,
  input  wire         rstn,
  input  wire         cpuStopClockN,
  output logic [15:0] stopCycles
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) stopCycles <= 16'h0;
    else if (!cpuStopClockN) stopCycles <= stopCycles + 16'h1;
  end
endmodule // pwsm_host_model
`default_nettype wire

/* File: pwsm_power_state_manager_tb_top.sv */
// self-checking bench for the power state manager over ahb-lite
// assumes zero-wait slave, shortened timer reloads, test tick bits
`timescale 1ns/10ps
`default_nettype none
module pwsm_power_state_manager_tb_top;
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        irqHighAct = 1'b0, irqZeroAct = 1'b0, nmiAct = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, cpuStopClockN, mgmtInterruptN;
  wire         gpLatchSelectN;
  wire  [7:0]  gpLatchData;
  wire  [15:0] stopCycles;
  wire         hready = hreadyout;
  integer      err_count = 0, n_tests = 0, seed = 32'hdec95c9d;
  integer      cyc = 0, i, j, b, k;
  logic [7:0]  rd, v;
  logic [15:0] sc0, sc;
  logic [7:0]  st [4] = '{8'h01, 8'h02, 8'h05, 8'h06};
  logic [7:0]  rl [5] = '{8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h40};
  logic [7:0]  tr [5] = '{8'h01, 8'h02, 8'h05, 8'h01, 8'h00};
  always #4 clk = ~clk;
  pwsm_power_state_manager #(.DOZE_RELOAD(9'h2), .STBY_RELOAD(5'h2),
    .SUSP_RELOAD(7'h5), .HK_RELOAD(9'h2)) dut (.clk, .rstn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .irqHighAct, .irqZeroAct, .nmiAct, .cpuStopClockN, .mgmtInterruptN,
    .gpLatchSelectN, .gpLatchData);
  pwsm_host_model host (.clk, .rstn, .cpuStopClockN, .stopCycles);
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input w, input [7:0] idx, input [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task act;
    k = $unsigned($random(seed)) % 3;
    {irqHighAct, irqZeroAct, nmiAct} <= 3'b100 >> k;
    repeat (2) @(posedge clk);
    {irqHighAct, irqZeroAct, nmiAct} <= 3'b000;
    repeat (4) @(posedge clk);
  endtask
  task poll(input [7:0] s);
    j = 0;
    do begin
      bus(1'b0, 8'h7a, 8'h00);
      j = j + 1;
    end while (rd[2:0] !== s[2:0] && j < 30);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i++) begin
      bus(1'b0, rl[i], 8'h00);
      chk(rd, 8'h00);
    end
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      bus(1'b1, 8'h7b, v);
      @(posedge clk);
      chk({7'h0, gpLatchSelectN}, 8'h00);
      chk(gpLatchData, v);
      bus(1'b0, 8'h7b, 8'h00);
      chk(rd, v);
    end
    $display("test gp latch done");
    for (i = 0; i < 3; i++) begin
      {irqHighAct, irqZeroAct, nmiAct} <= 3'b100 >> i;
      repeat (2) @(posedge clk);
      {irqHighAct, irqZeroAct, nmiAct} <= 3'b000;
      repeat (4) @(posedge clk);
      bus(1'b0, 8'h79, 8'h00);
      chk(rd, 8'h80 >> i);
      bus(1'b1, 8'h79, 8'h80 >> i);
      bus(1'b0, 8'h79, 8'h00);
      chk(rd, 8'h00);
    end
    $display("test activity status done");
    v = 8'h00;
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 8'h7a, i[7:0]);
      bus(1'b0, 8'h7a, 8'h00);
      if (i != 4 && i != 7) v = i[7:0];
      chk(rd, v);
    end
    $display("test state writes done");
    for (i = 0; i < 5; i++) begin
      bus(1'b0, 8'h88 + i[7:0], 8'h00);
      chk(rd, tr[i]);
    end
    $display("test timer readback done");
    bus(1'b1, 8'h90, 8'he0);
    bus(1'b1, 8'h7c, 8'h3c);
    for (i = 0; i < 4; i++) for (b = 0; b < 2; b++) begin
      bus(1'b1, 8'h72, {5'h0, b[0], 2'h0});
      bus(1'b1, 8'h7a, st[i]);
      act;
      bus(1'b0, 8'h7a, 8'h00);
      chk(rd, b ? st[i] : 8'h00);
      chk({7'h0, mgmtInterruptN}, b ? 8'h00 : 8'h01);
      if (b) chk({7'h0, cpuStopClockN}, 8'h01);
      bus(1'b1, 8'h79, 8'he0);
      bus(1'b1, 8'h72, 8'h00);
      repeat (4) @(posedge clk);
      chk({7'h0, mgmtInterruptN}, 8'h01);
    end
    $display("test system activity done");
    bus(1'b1, 8'h90, 8'h00);
    bus(1'b1, 8'h91, 8'he0);
    for (i = 0; i < 2; i++) begin
      bus(1'b1, 8'h7a, st[i]);
      act;
      bus(1'b0, 8'h7a, 8'h00);
      chk(rd, st[i + 2]);
      bus(1'b1, 8'h7a, 8'h20 | st[i + 2]);
      poll(st[i]);
      chk(rd & 8'h07, st[i]);
      bus(1'b0, 8'h79, 8'h00);
      chk(rd, 8'h00);
    end
    bus(1'b1, 8'h7a, 8'h00);
    bus(1'b1, 8'h91, 8'h00);
    $display("test housekeeping done");
    for (i = 0; i < 2; i++) for (b = 0; b < 2; b++) begin
      bus(1'b1, 8'h73, 8'hf0);
      bus(1'b1, 8'h72, b ? (8'h80 >> i) : 8'h00);
      bus(1'b1, 8'h7a, 8'h10 >> i);
      poll(b ? 8'h00 : 8'h01 + i[7:0]);
      repeat (40) if (b && mgmtInterruptN !== 1'b0) @(posedge clk);
      chk(rd & 8'h07, b ? 8'h00 : 8'h01 + i[7:0]);
      chk({7'h0, mgmtInterruptN}, b ? 8'h00 : 8'h01);
      bus(1'b1, 8'h7a, 8'h00);
      bus(1'b1, 8'h72, 8'h00);
    end
    bus(1'b1, 8'h73, 8'hf0);
    $display("test time-outs done");
    bus(1'b1, 8'h7c, 8'h1c);
    for (i = 0; i < 2; i++) begin
      bus(1'b1, 8'h7a, 8'h01 - i[7:0]);
      repeat (4) @(posedge clk);
      sc0 = stopCycles;
      repeat (20) @(posedge clk);
      sc = stopCycles - sc0;
      chk(sc[7:0], i ? 8'd0 : 8'd20);
    end
    bus(1'b1, 8'h7c, 8'h00);
    $display("test stop-clock done");
    close_out;
  end
endmodule // pwsm_power_state_manager_tb_top
`default_nettype wire
